// [src/pllc_top.sv]
/*
  pllc_top: control side of the loop clock generator, with an apb register
  file, lock detector, filter mode selection and lock interrupt.
  assumes: crystal_clock and vco_clock arrive as asynchronous square waves
  slower than half of clk_i; analog vco and filter live outside.
*/
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module pllc_top
  import pllc_pkg::*;
(
  input  wire logic        clk_i,            // 100 MHz system clock
  input  wire logic        rst_i,            // synchronous reset, high
  input  wire logic        psel_i,           // apb select
  input  wire logic        penable_i,        // apb enable
  input  wire logic        pwrite_i,         // apb direction
  input  wire logic [17:0] paddr_i,          // apb byte address
  input  wire logic [31:0] pwdata_i,         // apb write data
  output logic      [31:0] prdata_o,         // apb read data
  output logic             pready_o,         // apb ready
  output logic             pslverr_o,        // apb unmapped address
  input  wire logic        crystal_clock_i,  // crystal oscillator pin
  input  wire logic        vco_clock_i,      // vco output
  output logic             reference_clock_o,// buffered crystal copy
  output logic             loop_power_on_o,  // vco and filter power
  output logic             tracking_mode_o,  // filter in tracking mode
  output logic             pump_up_o,        // correction pulse, faster
  output logic             pump_dn_o,        // correction pulse, slower
  output logic             base_clock_sel_o, // base clock from vco
  output logic [7:0]       vco_range_o,      // vco_range_field to analog
  output logic             irq_o             // level interrupt
);

  pllc_if lp ();

  // ---------------------------------------------------------------
  // pin synchronisers and edge enables
  // ---------------------------------------------------------------
  logic [1:0] xs_reg, vs_reg;
  logic       xd_reg, vd_reg;
  logic       ref_en, vco_en;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xs_reg <= 2'b00;
      vs_reg <= 2'b00;
      xd_reg <= 1'b0;
      vd_reg <= 1'b0;
    end else begin
      xs_reg <= {xs_reg[0], crystal_clock_i};
      vs_reg <= {vs_reg[0], vco_clock_i};
      xd_reg <= xs_reg[1];
      vd_reg <= vs_reg[1];
    end
  end

  // reference_clock_in is the crystal copy; its rising edge drives the divider
  assign ref_en = xs_reg[1] && !xd_reg;
  assign vco_en = vs_reg[1] && !vd_reg;
  assign reference_clock_o = xs_reg[1];

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [3:0]  refdiv_reg, refdiv_next;
  logic [1:0]  pre_reg, pre_next;
  logic [11:0] mult_reg, mult_next;
  logic [7:0]  vrange_reg, vrange_next;
  logic        on_reg, on_next;
  logic        bcs_reg, bcs_next;
  logic        ie_reg, ie_next;
  logic        auto_reg, auto_next;
  logic        acqw_reg, acqw_next;
  logic [1:0]  ist_reg, ist_next;
  logic [1:0]  imask_reg, imask_next;
  logic        flag_reg, flag_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        err_reg, err_next;

  logic        wr, rd, hit;
  logic        lock_reg, acqd_reg;
  logic        lock_evt, acq_evt;
  logic        acq_eff;
  logic [31:0] wd;

  assign wr  = psel_i && penable_i && pwrite_i;
  assign rd  = psel_i && !penable_i && !pwrite_i;
  assign wd  = pwdata_i;
  assign hit = (paddr_i == PLLC_ADDR_REFDIV) || (paddr_i == PLLC_ADDR_CTRL) ||
               (paddr_i == PLLC_ADDR_BWCTL)  || (paddr_i == PLLC_ADDR_MULT) ||
               (paddr_i == PLLC_ADDR_VRANGE) || (paddr_i == PLLC_ADDR_ISTAT) ||
               (paddr_i == PLLC_ADDR_IMASK);

  // automatic: detector's choice; manual: software's bit
  assign acq_eff = auto_reg ? acqd_reg : acqw_reg;

  always_comb begin
    refdiv_next = refdiv_reg;
    pre_next    = pre_reg;
    mult_next   = mult_reg;
    vrange_next = vrange_reg;
    on_next     = on_reg;
    bcs_next    = bcs_reg;
    ie_next     = ie_reg;
    auto_next   = auto_reg;
    acqw_next   = acqw_reg;
    imask_next  = imask_reg;
    flag_next   = flag_reg;
    ist_next    = ist_reg;
    err_next    = 1'b0;
    rdata_next  = rdata_reg;
    if (wr && hit) begin
      case (paddr_i)
        PLLC_ADDR_REFDIV: if (!on_reg) refdiv_next = wd[3:0];
        PLLC_ADDR_MULT:   if (!on_reg) mult_next = wd[11:0];
        PLLC_ADDR_VRANGE: if (!on_reg) vrange_next = wd[7:0];
        PLLC_ADDR_CTRL: begin
          if (!on_reg) pre_next = wd[PLLC_CTRL_PRE_LO +: 2];
          if (!bcs_reg) on_next = wd[PLLC_CTRL_ON];
          bcs_next = wd[PLLC_CTRL_BCS];
          ie_next  = wd[PLLC_CTRL_IE];
        end
        PLLC_ADDR_BWCTL: begin
          auto_next = wd[PLLC_BW_AUTO];
          if (!auto_reg) acqw_next = wd[PLLC_BW_ACQ];
        end
        PLLC_ADDR_ISTAT: ist_next = ist_reg & ~wd[1:0];
        PLLC_ADDR_IMASK: imask_next = wd[1:0];
        default: ;
      endcase
    end
    // base select may only stand with the loop running and a range set
    if (!on_next || vrange_next == 8'h00) bcs_next = 1'b0;
    if (bcs_next) on_next = 1'b1;
    if (!auto_next) ie_next = 1'b0;
    // reading the control word clears the change flag; a new toggle wins
    if (rd && paddr_i == PLLC_ADDR_CTRL) flag_next = 1'b0;
    if (lock_evt) flag_next = 1'b1;
    if (!auto_reg) flag_next = 1'b0;
    if (lock_evt) ist_next[PLLC_IRQ_LOCK] = 1'b1;
    if (acq_evt) ist_next[PLLC_IRQ_ACQ] = 1'b1;
    if (psel_i && !penable_i) begin
      err_next   = !hit;
      rdata_next = 32'h0;
      case (paddr_i)
        PLLC_ADDR_REFDIV: rdata_next[3:0] = refdiv_reg;
        PLLC_ADDR_MULT:   rdata_next[11:0] = mult_reg;
        PLLC_ADDR_VRANGE: rdata_next[7:0] = vrange_reg;
        PLLC_ADDR_CTRL: begin
          rdata_next[PLLC_CTRL_IE]   = ie_reg;
          rdata_next[PLLC_CTRL_FLAG] = flag_reg && auto_reg;
          rdata_next[PLLC_CTRL_ON]   = on_reg;
          rdata_next[PLLC_CTRL_BCS]  = bcs_reg;
          rdata_next[PLLC_CTRL_PRE_LO +: 2] = pre_reg;
        end
        PLLC_ADDR_BWCTL: begin
          rdata_next[PLLC_BW_AUTO] = auto_reg;
          rdata_next[PLLC_BW_LOCK] = lock_reg && auto_reg;
          rdata_next[PLLC_BW_ACQ]  = acq_eff;
        end
        PLLC_ADDR_ISTAT: rdata_next[1:0] = ist_reg;
        PLLC_ADDR_IMASK: rdata_next[1:0] = imask_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refdiv_reg <= PLLC_RST_REFDIV;
      pre_reg    <= PLLC_RST_PRE;
      mult_reg   <= PLLC_RST_MULT;
      vrange_reg <= PLLC_RST_VRANGE;
      on_reg     <= 1'b0;
      bcs_reg    <= 1'b0;
      ie_reg     <= 1'b0;
      auto_reg   <= 1'b0;
      acqw_reg   <= 1'b0;
      ist_reg    <= 2'b00;
      imask_reg  <= PLLC_RST_IMASK;
      flag_reg   <= 1'b0;
      rdata_reg  <= 32'h0;
      err_reg    <= 1'b0;
    end else begin
      refdiv_reg <= refdiv_next;
      pre_reg    <= pre_next;
      mult_reg   <= mult_next;
      vrange_reg <= vrange_next;
      on_reg     <= on_next;
      bcs_reg    <= bcs_next;
      ie_reg     <= ie_next;
      auto_reg   <= auto_next;
      acqw_reg   <= acqw_next;
      ist_reg    <= ist_next;
      imask_reg  <= imask_next;
      flag_reg   <= flag_next;
      rdata_reg  <= rdata_next;
      err_reg    <= err_next;
    end
  end

  // ---------------------------------------------------------------
  // lock detector
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {LD_IDLE, LD_COUNT, LD_JUDGE} pllc_ld_e;
  pllc_ld_e               ld_st_reg, ld_st_next;
  logic [PLLC_LD_CW-1:0]  fbc_reg, fbc_next;
  logic [3:0]             win_reg, win_next;
  logic                   lock_next, acqd_next;
  logic [PLLC_LD_CW-1:0]  expect_cnt, diff;

  // PLLC_LD_WIN reference periods at divide R give this many feedback ticks
  // when locked: R relates to N*2^P through fb = ref; count is in fb ticks
  assign expect_cnt = PLLC_LD_CW'(PLLC_LD_WIN);
  assign diff = (fbc_reg > expect_cnt) ? fbc_reg - expect_cnt : expect_cnt - fbc_reg;

  always_comb begin
    ld_st_next = ld_st_reg;
    fbc_next   = fbc_reg;
    win_next   = win_reg;
    lock_next  = lock_reg;
    acqd_next  = acqd_reg;
    if (lp.div_fb_tick && fbc_reg != {PLLC_LD_CW{1'b1}}) fbc_next = fbc_reg + 1'b1;
    case (ld_st_reg)
      LD_IDLE: begin
        fbc_next = '0;
        win_next = 4'h0;
        if (lp.div_ref_tick) ld_st_next = LD_COUNT;
      end
      LD_COUNT: begin
        if (lp.div_ref_tick) begin
          if (win_reg == 4'(PLLC_LD_WIN - 1)) ld_st_next = LD_JUDGE;
          else win_next = win_reg + 4'h1;
        end
      end
      LD_JUDGE: begin
        lock_next  = diff <= PLLC_LD_TOL;
        acqd_next  = diff <= PLLC_ACQ_TOL;
        fbc_next   = '0;
        win_next   = 4'h0;
        ld_st_next = LD_COUNT;
      end
      default: ld_st_next = LD_IDLE;
    endcase
    if (!on_reg || !auto_reg) begin
      ld_st_next = LD_IDLE;
      lock_next  = 1'b0;
      acqd_next  = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ld_st_reg <= LD_IDLE;
      fbc_reg   <= '0;
      win_reg   <= 4'h0;
      lock_reg  <= 1'b0;
      acqd_reg  <= 1'b0;
    end else begin
      ld_st_reg <= ld_st_next;
      fbc_reg   <= fbc_next;
      win_reg   <= win_next;
      lock_reg  <= lock_next;
      acqd_reg  <= acqd_next;
    end
  end

  assign lock_evt = auto_reg && (lock_next != lock_reg);
  assign acq_evt  = auto_reg && (acqd_next != acqd_reg);

  // ---------------------------------------------------------------
  // divider core and outputs
  // ---------------------------------------------------------------
  assign lp.powered = on_reg;
  assign lp.ref_div = refdiv_reg;
  assign lp.pre_exp = pre_reg;
  assign lp.mult    = mult_reg;

  pllc_divcore u_core (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ref_en_i (ref_en),
    .vco_en_i (vco_en),
    .lp       (lp)
  );

  assign prdata_o         = rdata_reg;
  assign pready_o         = 1'b1;
  assign pslverr_o        = psel_i && penable_i && err_reg;
  assign loop_power_on_o  = on_reg;
  assign tracking_mode_o  = acq_eff;
  assign pump_up_o        = lp.pump_up;
  assign pump_dn_o        = lp.pump_dn;
  assign base_clock_sel_o = bcs_reg;
  assign vco_range_o      = vrange_reg;
  // lock toggles also need the enable bit; mode changes only the mask
  assign irq_o = (ist_reg[PLLC_IRQ_LOCK] && imask_reg[PLLC_IRQ_LOCK] && ie_reg) ||
                 (ist_reg[PLLC_IRQ_ACQ] && imask_reg[PLLC_IRQ_ACQ]);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_ie_manual_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !auto_reg |-> !ie_reg) else $error("irq enable set in manual mode");
  a_lock_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (psel_i && !penable_i && paddr_i == PLLC_ADDR_BWCTL && !auto_reg) |=>
    !prdata_o[PLLC_BW_LOCK]) else $error("lock read set in manual mode");
  a_acq_readonly: assert property (@(posedge clk_i) disable iff (rst_i)
    (auto_reg && wr && paddr_i == PLLC_ADDR_BWCTL) |=> acqw_reg == $past(acqw_reg))
    else $error("acquisition bit written in automatic mode");
  a_bcs_forced: assert property (@(posedge clk_i) disable iff (rst_i)
    (!on_reg || vrange_reg == 8'h00) |-> !bcs_reg) else $error("base select with loop off");
  a_prog_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(on_reg) && on_reg |-> $stable(mult_reg) && $stable(refdiv_reg))
    else $error("programming changed while loop on");
  a_on_held: assert property (@(posedge clk_i) disable iff (rst_i)
    bcs_reg |-> on_reg) else $error("loop off with base select");
  a_ld_rate: assert property (@(posedge clk_i) disable iff (rst_i)
    (ld_st_reg == LD_COUNT && !lp.div_ref_tick) |=> win_reg == $past(win_reg))
    else $error("window advanced without reference edge");
  a_flag_on_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    lock_evt |=> flag_reg && ist_reg[PLLC_IRQ_LOCK]) else $error("lock toggle lost");
  a_manual_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    !auto_reg |=> !lock_reg && !flag_reg) else $error("lock or flag set in manual mode");

endmodule

// [src/pllc_pkg.sv]
/*
  pllc_pkg: register offsets, field positions, reset values and timing
  counts for the loop clock generator control block.
  assumes: included before every other design file.
*/
package pllc_pkg;

  // ---------------------------------------------------------------
  // register byte addresses (printed offsets are not all multiples of
  // four, so each is an index and the byte address is four times it)
  // ---------------------------------------------------------------
  localparam logic [15:0] PLLC_IDX_REFDIV = 16'h1095;
  localparam logic [15:0] PLLC_IDX_CTRL   = 16'h1096;
  localparam logic [15:0] PLLC_IDX_BWCTL  = 16'h1097;
  localparam logic [15:0] PLLC_IDX_MULT   = 16'h1098;
  localparam logic [15:0] PLLC_IDX_VRANGE = 16'h1099;
  localparam logic [15:0] PLLC_IDX_ISTAT  = 16'h109a;
  localparam logic [15:0] PLLC_IDX_IMASK  = 16'h109b;
  localparam logic [17:0] PLLC_ADDR_REFDIV = {PLLC_IDX_REFDIV, 2'b00};
  localparam logic [17:0] PLLC_ADDR_CTRL   = {PLLC_IDX_CTRL, 2'b00};
  localparam logic [17:0] PLLC_ADDR_BWCTL  = {PLLC_IDX_BWCTL, 2'b00};
  localparam logic [17:0] PLLC_ADDR_MULT   = {PLLC_IDX_MULT, 2'b00};
  localparam logic [17:0] PLLC_ADDR_VRANGE = {PLLC_IDX_VRANGE, 2'b00};
  localparam logic [17:0] PLLC_ADDR_ISTAT  = {PLLC_IDX_ISTAT, 2'b00};
  localparam logic [17:0] PLLC_ADDR_IMASK  = {PLLC_IDX_IMASK, 2'b00};

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PLLC_CTRL_IE     = 7;  // lock_irq_enable
  localparam int PLLC_CTRL_FLAG   = 6;  // lock_change_flag
  localparam int PLLC_CTRL_ON     = 5;  // loop_power_on
  localparam int PLLC_CTRL_BCS    = 4;  // base_clock_select
  localparam int PLLC_CTRL_PRE_LO = 0;  // prescale exponent P, 2 bits
  localparam int PLLC_BW_AUTO     = 7;
  localparam int PLLC_BW_LOCK     = 6;
  localparam int PLLC_BW_ACQ      = 5;
  localparam int PLLC_IRQ_LOCK    = 0;  // lock toggled
  localparam int PLLC_IRQ_ACQ     = 1;  // filter mode changed

  // ---------------------------------------------------------------
  // reset values and widths
  // ---------------------------------------------------------------
  localparam logic [3:0]  PLLC_RST_REFDIV = 4'h1;
  localparam logic [1:0]  PLLC_RST_PRE    = 2'h0;
  localparam logic [11:0] PLLC_RST_MULT   = 12'h001;
  localparam logic [7:0]  PLLC_RST_VRANGE = 8'h40;
  localparam logic [1:0]  PLLC_RST_IMASK  = 2'h0;

  // ---------------------------------------------------------------
  // lock detector: window of divided reference periods and tolerance
  // ---------------------------------------------------------------
  localparam int          PLLC_LD_WIN    = 8;
  localparam logic [15:0] PLLC_LD_TOL    = 16'h0002; // lock tolerance
  localparam logic [15:0] PLLC_ACQ_TOL   = 16'h0004; // tracking tolerance
  localparam int          PLLC_LD_CW     = 16;

endpackage

// [src/pllc_if.sv]
/*
  pllc_if: carries the loop settings from the register file to the divider
  core and the divided edges and correction pulses back.
  assumes: one clock domain on both sides.
*/
`timescale 1ns/1ps
interface pllc_if;
  logic        powered;      // loop_power_on
  logic [3:0]  ref_div;      // R
  logic [1:0]  pre_exp;      // P
  logic [11:0] mult;         // N
  logic        div_ref_tick; // divided_reference edge
  logic        div_fb_tick;  // divided_feedback edge
  logic        pump_up;      // correction pulse, raise vco
  logic        pump_dn;      // correction pulse, lower vco

  modport ctrl (output powered, ref_div, pre_exp, mult,
                input  div_ref_tick, div_fb_tick, pump_up, pump_dn);
  modport core (input  powered, ref_div, pre_exp, mult,
                output div_ref_tick, div_fb_tick, pump_up, pump_dn);
endinterface

// [src/pllc_divcore.sv]
/*
  pllc_divcore: reference modulo divider, feedback prescaler and modulo
  divider, and the phase comparator.
  assumes: reference and vco edges arrive as one-cycle enables on clk_i.
*/
`timescale 1ns/1ps
module pllc_divcore
  import pllc_pkg::*;
(
  input  wire logic clk_i,     // system clock
  input  wire logic rst_i,     // synchronous reset
  input  wire logic ref_en_i,  // reference_clock_in edge
  input  wire logic vco_en_i,  // vco_clock edge
  pllc_if.core      lp         // settings and results
);

  logic [3:0]  rcnt_reg, rcnt_next;
  logic [6:0]  pcnt_reg, pcnt_next;
  logic [11:0] ncnt_reg, ncnt_next;
  logic        rtick_reg, rtick_next;
  logic        ftick_reg, ftick_next;
  logic        up_reg, up_next;
  logic        dn_reg, dn_next;
  logic        pre_tick;
  logic [6:0]  pre_mask;

  // ---------------------------------------------------------------
  // dividers
  // ---------------------------------------------------------------
  assign pre_mask = 7'((7'h1 << lp.pre_exp) - 7'h1);
  assign pre_tick = vco_en_i && ((pcnt_reg & pre_mask) == pre_mask);

  always_comb begin
    rcnt_next  = rcnt_reg;
    pcnt_next  = pcnt_reg;
    ncnt_next  = ncnt_reg;
    rtick_next = 1'b0;
    ftick_next = 1'b0;
    up_next    = up_reg;
    dn_next    = dn_reg;
    if (!lp.powered) begin
      rcnt_next = 4'h0;
      pcnt_next = 7'h0;
      ncnt_next = 12'h0;
      up_next   = 1'b0;
      dn_next   = 1'b0;
    end else begin
      if (ref_en_i) begin
        // a zero ratio behaves as one rather than stopping the loop
        if (rcnt_reg + 4'h1 >= lp.ref_div) begin
          rcnt_next  = 4'h0;
          rtick_next = 1'b1;
        end else begin
          rcnt_next = rcnt_reg + 4'h1;
        end
      end
      if (vco_en_i) begin
        pcnt_next = pre_tick ? 7'h0 : pcnt_reg + 7'h1;
      end
      if (pre_tick) begin
        if (ncnt_reg + 12'h1 >= lp.mult) begin
          ncnt_next  = 12'h0;
          ftick_next = 1'b1;
        end else begin
          ncnt_next = ncnt_reg + 12'h1;
        end
      end
      // pulse from one edge to the other: leading side sets direction
      if (rtick_next && ftick_next) begin
        up_next = 1'b0;
        dn_next = 1'b0;
      end else if (rtick_next) begin
        if (dn_reg) dn_next = 1'b0;
        else up_next = 1'b1;
      end else if (ftick_next) begin
        if (up_reg) up_next = 1'b0;
        else dn_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rcnt_reg  <= 4'h0;
      pcnt_reg  <= 7'h0;
      ncnt_reg  <= 12'h0;
      rtick_reg <= 1'b0;
      ftick_reg <= 1'b0;
      up_reg    <= 1'b0;
      dn_reg    <= 1'b0;
    end else begin
      rcnt_reg  <= rcnt_next;
      pcnt_reg  <= pcnt_next;
      ncnt_reg  <= ncnt_next;
      rtick_reg <= rtick_next;
      ftick_reg <= ftick_next;
      up_reg    <= up_next;
      dn_reg    <= dn_next;
    end
  end

  assign lp.div_ref_tick = rtick_reg;
  assign lp.div_fb_tick  = ftick_reg;
  assign lp.pump_up      = up_reg;
  assign lp.pump_dn      = dn_reg;

  a_pump_exclusive: assert property (@(posedge clk_i) disable iff (rst_i)
    !(up_reg && dn_reg)) else $error("both correction directions active");

endmodule

// [sim/pllc_top_tb.sv]
/*
  pllc_top_tb: self-checking bench for the loop clock control block,
  with apb master tasks, register model and square wave sources.
  assumes: pllc_pkg compiled first; slave answers through pready_o.
*/
`timescale 1ns/1ps
module pllc_top_tb;
  import pllc_pkg::*;
  logic        clk_i, rst_i, psel, pen, pwr, xc, vc, rdy, err, e, rck, on_o, trk, up, dn, bcs_o, irq;
  logic [17:0] pa;
  logic [31:0] pwd, prd, r;
  logic [7:0]  vr_o, m_vr;
  logic [3:0]  m_r;
  logic [11:0] m_n;
  logic [1:0]  m_pre, m_ist, m_msk, xh;
  logic        m_ie, m_flag, m_on, m_bcs, m_auto, m_lock, m_acq, m_acqw;
  logic [17:0] al[8];
  int          n_fail, n_compared, vh, xcnt, vcnt, k, nu, nd;
  pllc_top dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
    .crystal_clock_i(xc), .vco_clock_i(vc), .reference_clock_o(rck), .loop_power_on_o(on_o),
    .tracking_mode_o(trk), .pump_up_o(up), .pump_dn_o(dn), .base_clock_sel_o(bcs_o),
    .vco_range_o(vr_o), .irq_o(irq));
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  // crystal period 8 clocks; vco half period vh clocks, both slower than clk/4
  always @(posedge clk_i) begin
    xcnt <= (xcnt == 3) ? 0 : xcnt + 1;
    if (xcnt == 3) xc <= ~xc;
    vcnt <= (vcnt >= vh - 1) ? 0 : vcnt + 1;
    if (vcnt >= vh - 1) vc <= ~vc;
    xh <= {xh[0], xc};
  end
  // ---------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------
  task automatic results;
    $display("counts: %0d compared, %0d mismatched", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] x, input string m);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int t;
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk_i);
    pen <= 1;
    t = 0;
    do begin @(posedge clk_i); t++; end while (rdy !== 1'b1 && t < 20);
    if (rdy !== 1'b1) begin n_fail++; results(); end
    r = prd; e = err; psel <= 0; pen <= 0;
    @(posedge clk_i);
  endtask
  function automatic logic [32:0] ev(input logic [17:0] a);
    case (a)
      PLLC_ADDR_REFDIV: ev = {29'h0, m_r};
      PLLC_ADDR_CTRL:   ev = {25'h0, m_ie, m_flag & m_auto, m_on, m_bcs, 2'h0, m_pre};
      PLLC_ADDR_BWCTL:  ev = {25'h0, m_auto, m_lock & m_auto, m_auto ? m_acq : m_acqw, 5'h0};
      PLLC_ADDR_MULT:   ev = {21'h0, m_n};
      PLLC_ADDR_VRANGE: ev = {25'h0, m_vr};
      PLLC_ADDR_ISTAT:  ev = {31'h0, m_ist};
      PLLC_ADDR_IMASK:  ev = {31'h0, m_msk};
      default:          ev = {1'b1, 32'h0};
    endcase
  endfunction
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    logic non;
    apb(1, a, d);
    non = m_bcs | d[5];
    case (a)
      PLLC_ADDR_REFDIV: if (!m_on) m_r = d[3:0];
      PLLC_ADDR_MULT:   if (!m_on) m_n = d[11:0];
      PLLC_ADDR_VRANGE: if (!m_on) m_vr = d[7:0];
      PLLC_ADDR_CTRL: begin
        if (!m_on) m_pre = d[1:0];
        m_ie = m_auto & d[7]; m_bcs = non & (m_vr != 0) & d[4]; m_on = non;
      end
      PLLC_ADDR_BWCTL: begin
        if (!m_auto) m_acqw = d[5];
        m_auto = d[7];
        m_ie = m_ie & d[7];
        if (!d[7]) {m_lock, m_acq, m_flag} = 3'h0;
      end
      PLLC_ADDR_ISTAT:  m_ist = m_ist & ~d[1:0];
      PLLC_ADDR_IMASK:  m_msk = d[1:0];
      default: ;
    endcase
  endtask
  task automatic rd(input logic [17:0] a);
    apb(0, a, 32'h0);
    chk({e, r}, ev(a), "read");
    if (a == PLLC_ADDR_CTRL) m_flag = 0;
  endtask
  // polls lock status; bounded so a dead detector ends the run
  task automatic poll(input logic want);
    k = 0;
    do begin apb(0, PLLC_ADDR_BWCTL, 32'h0); k++; end while (r[PLLC_BW_LOCK] !== want && k < 300);
    if (k >= 300) begin n_fail++; results(); end
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    rst_i = 1; psel = 0; pen = 0; pwr = 0; pa = 0; pwd = 0; xc = 0; vc = 0; vh = 4; xcnt = 0; vcnt = 0;
    n_fail = 0; n_compared = 0; m_r = 1; m_n = 1; m_vr = 8'h40; m_pre = 0; m_ist = 0; m_msk = 0;
    {m_ie, m_flag, m_on, m_bcs, m_auto, m_lock, m_acq, m_acqw} = 8'h0;
    al = '{PLLC_ADDR_REFDIV, PLLC_ADDR_CTRL, PLLC_ADDR_BWCTL, PLLC_ADDR_MULT, PLLC_ADDR_VRANGE,
           PLLC_ADDR_ISTAT, PLLC_ADDR_IMASK, 18'h00004};
    k = $urandom(32'hcc8b);
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    foreach (al[i]) rd(al[i]);
    chk({25'h0, vr_o}, 33'h40, "range port");
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      foreach (al[j]) if (j == 0 || j == 3 || j == 4) begin wr(al[j], $urandom); rd(al[j]); end
    end
    chk({25'h0, vr_o}, {25'h0, m_vr}, "range port");
    wr(PLLC_ADDR_REFDIV, 32'h1); wr(PLLC_ADDR_MULT, 32'h1); wr(PLLC_ADDR_VRANGE, 32'h40);
    $display("test programming done");
    wr(PLLC_ADDR_CTRL, 32'hfc); rd(PLLC_ADDR_CTRL);
    chk({31'h0, on_o, bcs_o}, 33'h3, "power and select ports");
    wr(PLLC_ADDR_REFDIV, 32'h5); rd(PLLC_ADDR_REFDIV);
    wr(PLLC_ADDR_CTRL, 32'h0); rd(PLLC_ADDR_CTRL);
    wr(PLLC_ADDR_CTRL, 32'h0); wr(PLLC_ADDR_VRANGE, 32'h0);
    wr(PLLC_ADDR_CTRL, 32'h30); rd(PLLC_ADDR_CTRL);
    wr(PLLC_ADDR_CTRL, 32'h0); wr(PLLC_ADDR_VRANGE, 32'h40);
    $display("test interlocks done");
    wr(PLLC_ADDR_CTRL, 32'h20); wr(PLLC_ADDR_BWCTL, 32'h20);
    chk({32'h0, trk}, 33'h1, "tracking port");
    repeat (300) @(posedge clk_i);
    rd(PLLC_ADDR_BWCTL); rd(PLLC_ADDR_CTRL);
    wr(PLLC_ADDR_BWCTL, 32'h0);
    chk({32'h0, trk}, 33'h0, "tracking port");
    $display("test manual mode done");
    wr(PLLC_ADDR_IMASK, 32'h3); wr(PLLC_ADDR_BWCTL, 32'h80); wr(PLLC_ADDR_CTRL, 32'ha0);
    poll(1);
    m_lock = 1; m_acq = 1; m_ist = 3; m_flag = 1;
    repeat (70) @(posedge clk_i);
    rd(PLLC_ADDR_BWCTL); rd(PLLC_ADDR_ISTAT);
    chk({32'h0, irq}, 33'h1, "irq");
    rd(PLLC_ADDR_CTRL); rd(PLLC_ADDR_CTRL);
    wr(PLLC_ADDR_BWCTL, 32'h80); rd(PLLC_ADDR_BWCTL);
    wr(PLLC_ADDR_ISTAT, 32'h3);
    chk({32'h0, irq}, 33'h0, "irq");
    $display("test lock done");
    wr(PLLC_ADDR_IMASK, 32'h0); vh = 16;
    poll(0);
    m_lock = 0; m_acq = 0; m_ist = 3; m_flag = 1;
    nu = 0; nd = 0;
    repeat (64) begin
      @(posedge clk_i);
      nu += up;
      nd += dn;
      chk({32'h0, rck}, {32'h0, xh[1]}, "reference copy");
    end
    chk({32'h0, nu > nd}, 33'h1, "pump direction");
    rd(PLLC_ADDR_BWCTL); rd(PLLC_ADDR_ISTAT);
    chk({32'h0, irq}, 33'h0, "masked irq");
    wr(PLLC_ADDR_IMASK, 32'h1);
    chk({32'h0, irq}, 33'h1, "irq");
    wr(PLLC_ADDR_BWCTL, 32'h0); rd(PLLC_ADDR_CTRL); rd(PLLC_ADDR_BWCTL);
    chk({32'h0, irq}, 33'h0, "irq");
    $display("test unlock done");
    wr(PLLC_ADDR_CTRL, 32'h0); wr(PLLC_ADDR_REFDIV, 32'h4); wr(PLLC_ADDR_MULT, 32'h2);
    wr(PLLC_ADDR_CTRL, 32'ha1); wr(PLLC_ADDR_BWCTL, 32'h80); vh = 4;
    poll(1);
    m_lock = 1; m_acq = 1; m_ist = 3; m_flag = 1;
    rd(PLLC_ADDR_BWCTL); rd(PLLC_ADDR_CTRL); rd(PLLC_ADDR_ISTAT);
    $display("test divide ratios done");
    results();
  end
endmodule
